// ### rtl/nswap_core.sv
// instruction-cycle sequencer with register file for swap and subtract with borrow
`timescale 1ns/1ps
module nswap_core
  import nswap_pkg::*;
#(
  parameter int DEPTH = 1 << ADDR_W
)
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // instruction issue
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr_word,
  input  wire logic [3:0]  bank_select_register,
  output logic             instr_ready,
  // state
  output logic      [7:0]  working_register,
  output flags_s           status_flags,
  output logic             cycle_done,
  output logic             illegal_op,
  output mem_wr_s          mem_write
);
  // cleared at power-up only, so every read is defined
  logic [7:0]        mem [DEPTH] = '{default: 8'h00};
  quarter_e          q_reg, q_next;
  logic [15:0]       ir_reg, ir_next;
  logic [3:0]        bank_reg, bank_next;
  logic [ADDR_W-1:0] ea_reg, ea_next;
  logic [7:0]        f_reg, f_next;
  logic [7:0]        res_reg, res_next;
  flags_s            fl_reg, fl_next, alu_fl;
  logic [7:0]        w_reg, w_next, alu_res;
  logic              done_reg, done_next, ill_reg, ill_next;
  mem_wr_s           wr_reg, wr_next;
  logic              is_swap, is_subb, dest_f, acc_a;

  assign is_swap = (ir_reg[15:10] == OPC_SWAP);
  assign is_subb = (ir_reg[15:10] == OPC_SUBB);
  assign dest_f  = ir_reg[9];
  assign acc_a   = ir_reg[8];

  nswap_alu u_alu (
    .f_val     (f_reg),
    .w_val     (w_reg),
    .flags_in  (fl_reg),
    .is_swap   (is_swap),
    .result    (alu_res),
    .flags_out (alu_fl)
  );

  // ====================================================
  // quarter sequencer
  always_comb begin
    q_next    = q_reg;
    ir_next   = ir_reg;
    bank_next = bank_reg;
    ea_next   = ea_reg;
    f_next    = f_reg;
    res_next  = res_reg;
    fl_next   = fl_reg;
    w_next    = w_reg;
    done_next = 1'b0;
    ill_next  = ill_reg;
    wr_next   = '{we: 1'b0, addr: ea_reg, data: res_reg};
    unique case (q_reg)
      Q_DECODE: begin
        if (instr_valid) begin
          ir_next  = instr_word;
          bank_next = bank_select_register;
          q_next   = Q_READ;
        end
      end
      Q_READ: begin
        if (acc_a) begin
          ea_next = {bank_reg, ir_reg[7:0]};
        end else begin
          ea_next = {(ir_reg[7:0] < ACCESS_SPLIT) ? ACCESS_LO_BANK : ACCESS_HI_BANK, ir_reg[7:0]};
        end
        q_next = Q_PROCESS;
      end
      Q_PROCESS: begin
        f_next   = mem[ea_reg];
        ill_next = ~(is_swap | is_subb);
        q_next   = Q_WRITE;
      end
      Q_WRITE: begin
        res_next  = alu_res;
        done_next = 1'b1;
        q_next    = Q_DECODE;
        if (is_swap | is_subb) begin
          if (is_subb) begin
            fl_next = alu_fl;
          end
          if (dest_f) begin
            wr_next = '{we: 1'b1, addr: ea_reg, data: alu_res};
          end else begin
            w_next = alu_res;
          end
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      q_reg    <= Q_DECODE;
      ir_reg   <= 16'h0000;
      bank_reg <= BANK_RST;
      ea_reg   <= '0;
      f_reg    <= 8'h00;
      res_reg  <= 8'h00;
      fl_reg   <= flags_s'(FLAGS_RST);
      w_reg    <= WORKING_RST;
      done_reg <= 1'b0;
      ill_reg  <= 1'b0;
      wr_reg   <= '0;
    end else begin
      q_reg    <= q_next;
      ir_reg   <= ir_next;
      bank_reg <= bank_next;
      ea_reg   <= ea_next;
      f_reg    <= f_next;
      res_reg  <= res_next;
      fl_reg   <= fl_next;
      w_reg    <= w_next;
      done_reg <= done_next;
      ill_reg  <= ill_next;
      wr_reg   <= wr_next;
    end
  end

  // data memory, not touched by reset
  always_ff @(posedge sys_clk) begin
    if (wr_next.we) begin
      mem[wr_next.addr] <= wr_next.data;
    end
  end

  assign instr_ready      = (q_reg == Q_DECODE);
  assign working_register = w_reg;
  assign status_flags     = fl_reg;
  assign cycle_done       = done_reg;
  assign illegal_op       = ill_reg;
  assign mem_write        = wr_reg;

  // ====================================================
  // assertions
  AST_SWAP_NIB: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (q_reg == Q_WRITE && is_swap) |-> alu_res == {f_reg[3:0], f_reg[7:4]})
    else $error("swap result wrong");
  AST_DEST_W: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (q_reg == Q_WRITE && is_swap && !dest_f) |=> (w_reg == $past(alu_res) && !mem_write.we))
    else $error("working register not written");
  AST_DEST_F: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (q_reg == Q_WRITE && is_swap && dest_f) |=> (mem_write.we && mem_write.data == $past(alu_res)
      && $stable(w_reg)))
    else $error("source not written back");
  AST_ACCESS: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (q_reg == Q_READ && !acc_a) |=>
      ea_reg == {($past(ir_reg[7]) ? ACCESS_HI_BANK : ACCESS_LO_BANK), $past(ir_reg[7:0])})
    else $error("access bank wrong");
  AST_BANKED: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (q_reg == Q_READ && acc_a) |=> ea_reg == {$past(bank_reg), $past(ir_reg[7:0])})
    else $error("banked address wrong");
  AST_DECODE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (q_reg == Q_WRITE) |-> (illegal_op == !(ir_reg[15:10] inside {6'h0E, 6'h16})
      && is_swap == (ir_reg[15:10] == 6'h0E)))
    else $error("opcode decode wrong");
  AST_ILLEGAL_KEEP: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (q_reg == Q_WRITE && !is_swap && !is_subb) |=>
      ($stable(w_reg) && $stable(status_flags) && !mem_write.we))
    else $error("unknown opcode changed state");
  AST_SUBB: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (q_reg == Q_WRITE && is_subb) |=> status_flags.z == (res_reg == 8'h00)
      && res_reg == $past(f_reg - w_reg - {7'h00, ~fl_reg.c}))
    else $error("subtract with borrow wrong");
  AST_SUBB_CARRY: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (q_reg == Q_WRITE && is_subb) |=>
      status_flags.c == ($past({1'b0, f_reg}) >= $past({1'b0, w_reg} + {8'h00, ~fl_reg.c})))
    else $error("subtract with borrow carry wrong");
  AST_SUBB_NEG: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (q_reg == Q_WRITE && is_subb) |=> status_flags.n == res_reg[7])
    else $error("subtract with borrow sign wrong");
  AST_ONE_CYCLE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (instr_ready && instr_valid) |=> ##2 (q_reg == Q_WRITE) ##1 (cycle_done && instr_ready))
    else $error("cycle not four quarters");
  AST_SWAP_FLAGS: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (q_reg == Q_WRITE && is_swap) |=> $stable(status_flags))
    else $error("swap changed flags");
  COV_SWAP_W: cover property (@(posedge sys_clk) q_reg == Q_WRITE && is_swap && !dest_f);
  COV_SWAP_F: cover property (@(posedge sys_clk) q_reg == Q_WRITE && is_swap && dest_f);
  COV_SUBB: cover property (@(posedge sys_clk) q_reg == Q_WRITE && is_subb);
  COV_ILLEGAL: cover property (@(posedge sys_clk) q_reg == Q_WRITE && !is_swap && !is_subb);
  COV_BANKED: cover property (@(posedge sys_clk) q_reg == Q_READ && acc_a);
endmodule

// ### pkg/nswap_pkg.sv
// constants and types for the nibble-swap / subtract-with-borrow datapath
// Summary of operation
// - the swap places source bits 3:0 in result bits 7:4 and source bits 7:4 in result bits 3:0.
// - with the destination bit at 0 the swapped byte goes to the working register and the source stays unchanged.
// - with the destination bit at 1 (the default) the swapped byte is written back to the source register.
// - with the access bit at 0 the operand address lies in the access bank and the bank select value is ignored.
// - with the access bit at 1 the operand address lies in the bank named by the bank select register.
// - subtract with borrow computes register minus working register minus inverted carry and sets N, OV, C, DC and Z.
package nswap_pkg;
  localparam int          ADDR_W         = 12;
  localparam logic [5:0]  OPC_SWAP       = 6'h0E;
  localparam logic [5:0]  OPC_SUBB       = 6'h16;
  localparam logic [7:0]  WORKING_RST    = 8'h00;
  localparam logic [3:0]  BANK_RST       = 4'h0;
  localparam logic [4:0]  FLAGS_RST      = 5'h00;
  localparam logic [7:0]  ACCESS_SPLIT   = 8'h80;
  localparam logic [3:0]  ACCESS_HI_BANK = 4'hF;
  localparam logic [3:0]  ACCESS_LO_BANK = 4'h0;

  typedef enum logic [3:0] {
    Q_DECODE  = 4'b0001,
    Q_READ    = 4'b0010,
    Q_PROCESS = 4'b0100,
    Q_WRITE   = 4'b1000
  } quarter_e;

  // flags: n, ov, z, dc, c
  typedef struct packed {
    logic n;
    logic ov;
    logic z;
    logic dc;
    logic c;
  } flags_s;

  typedef struct packed {
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } mem_wr_s;
endpackage

// ### rtl/nswap_alu.sv
// combinational arithmetic for swap and subtract with borrow
`timescale 1ns/1ps
module nswap_alu
  import nswap_pkg::*;
(
  // operands
  input  wire logic [7:0] f_val,
  input  wire logic [7:0] w_val,
  input  wire flags_s     flags_in,
  input  wire logic       is_swap,
  // results
  output logic      [7:0] result,
  output flags_s          flags_out
);
  logic [8:0] diff;
  logic [4:0] low;
  always_comb begin
    // borrow in is the inverted carry
    diff      = {1'b0, f_val} - {1'b0, w_val} - {8'h00, ~flags_in.c};
    low       = {1'b0, f_val[3:0]} - {1'b0, w_val[3:0]} - {4'h0, ~flags_in.c};
    flags_out = flags_in;
    if (is_swap) begin
      result = {f_val[3:0], f_val[7:4]};
    end else begin
      result       = diff[7:0];
      flags_out.c  = ~diff[8];
      flags_out.dc = ~low[4];
      flags_out.z  = (diff[7:0] == 8'h00);
      flags_out.n  = diff[7];
      flags_out.ov = (f_val[7] ^ w_val[7]) & (f_val[7] ^ diff[7]);
    end
  end
endmodule

// ### testbench/nibble_swap_alu_op_tb.sv
// self-checking bench for the swap and subtract-with-borrow core
`timescale 1ns/1ps
module nibble_swap_alu_op_tb;
  import nswap_pkg::*;
  typedef struct {logic we; logic [11:0] addr; logic [7:0] data; logic [7:0] w; flags_s fl; int t;} note_s;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        instr_valid = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic [3:0]  bank_sel = 4'h0;
  logic        instr_ready, cycle_done, illegal_op;
  logic [7:0]  working_register;
  flags_s      status_flags;
  mem_wr_s     mem_write;
  int          n_errors = 0;
  int          n_compared = 0;
  int          cyc = 0;
  logic [31:0] rng = 32'h27;
  note_s       q[$];
  // reference state kept from the rules
  logic [7:0]  model_mem [logic [11:0]];
  logic [7:0]  model_w = WORKING_RST;
  flags_s      model_fl = flags_s'(FLAGS_RST);

  nswap_core nswap_core_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
    .instr_word(instr_word), .bank_select_register(bank_sel), .instr_ready(instr_ready),
    .working_register(working_register), .status_flags(status_flags), .cycle_done(cycle_done),
    .illegal_op(illegal_op), .mem_write(mem_write));

  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_errors++;
      summarize();
    end
  end

  function automatic logic [31:0] xorshift();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  task automatic check(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // offer one word, hold it until taken, note the expected result
  task automatic issue(input logic [5:0] opc, input logic d, input logic a, input logic [7:0] f,
                       input logic [3:0] b);
    note_s       n;
    logic [7:0]  v;
    logic        bw;
    int          sd;
    @(posedge sys_clk);
    instr_valid <= 1'b1;
    instr_word  <= {opc, d, a, f};
    bank_sel    <= b;
    do @(posedge sys_clk); while (instr_ready !== 1'b1);
    instr_valid <= 1'b0;
    n.we   = d;
    n.addr = a ? {b, f} : ((f < ACCESS_SPLIT) ? {ACCESS_LO_BANK, f} : {ACCESS_HI_BANK, f});
    n.t    = cyc;
    v      = model_mem.exists(n.addr) ? model_mem[n.addr] : 8'h00;
    bw     = ~model_fl.c;
    if (opc == OPC_SWAP) begin
      v = {v[3:0], v[7:4]};
    end else if (opc == OPC_SUBB) begin
      sd          = int'(signed'(v)) - int'(signed'(model_w)) - int'(bw);
      model_fl.c  = ({1'b0, v} >= ({1'b0, model_w} + {8'h00, bw}));
      model_fl.dc = ({1'b0, v[3:0]} >= ({1'b0, model_w[3:0]} + {4'h0, bw}));
      model_fl.ov = (sd > 127) || (sd < -128);
      v           = v - model_w - {7'h00, bw};
      model_fl.n  = v[7];
      model_fl.z  = (v == 8'h00);
    end
    if (opc == OPC_SWAP || opc == OPC_SUBB) begin
      if (d) begin
        model_mem[n.addr] = v;
      end else begin
        model_w = v;
      end
      n.data = v;
      n.w    = model_w;
      n.fl   = model_fl;
      q.push_back(n);
    end
  endtask

  // watcher: pairs each completion with the oldest note
  always @(negedge sys_clk) begin
    note_s n;
    if (!sys_rst && cycle_done === 1'b1 && q.size() > 0) begin
      n = q.pop_front();
      check("latency", 12'(cyc - n.t), 12'h004);
      check("we", 12'(mem_write.we), 12'(n.we));
      if (n.we) check("addr", mem_write.addr, n.addr);
      if (n.we) check("data", 12'(mem_write.data), 12'(n.data));
      check("working_register", 12'(working_register), 12'(n.w));
      check("flags", 12'(status_flags), 12'(n.fl));
      check("illegal", 12'(illegal_op), 12'h000);
    end
  end

  logic [31:0] r;
  logic [5:0]  bad_opc [4] = '{6'h00, 6'h0F, 6'h17, 6'h3F};
  initial begin
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    // seed cells and the working register with nonzero values
    issue(OPC_SUBB, 1'b1, 1'b0, 8'h7F, 4'h5);
    issue(OPC_SUBB, 1'b0, 1'b0, 8'h7F, 4'h5);
    issue(OPC_SUBB, 1'b1, 1'b0, 8'h80, 4'hC);
    issue(OPC_SUBB, 1'b1, 1'b1, 8'hFF, 4'hA);
    issue(OPC_SWAP, 1'b1, 1'b0, 8'h7F, 4'h5);
    issue(OPC_SWAP, 1'b1, 1'b0, 8'h80, 4'h5);
    issue(OPC_SWAP, 1'b1, 1'b1, 8'hFF, 4'hA);
    issue(OPC_SWAP, 1'b0, 1'b1, 8'h80, 4'hF);
    // mixed swap and subtract over a small cell pool
    for (int i = 0; i < 48; i++) begin
      r = xorshift();
      issue(r[14] ? OPC_SWAP : OPC_SUBB, r[12], r[13], {r[7], 4'h0, r[2:0]}, r[13] ? {4{r[8]}} : r[11:8]);
    end
    repeat (10) @(posedge sys_clk);
    foreach (bad_opc[k]) begin
      r = xorshift();
      issue(bad_opc[k], 1'b1, r[13], r[7:0], r[11:8]);
      repeat (8) @(posedge sys_clk);
      q.delete();
      check("illegal_set", 12'(illegal_op), 12'h001);
      check("w_kept", 12'(working_register), 12'(model_w));
    end
    for (int i = 0; i < 8; i++) begin
      r = xorshift();
      issue(OPC_SUBB, r[12], r[13], r[7:0], r[11:8]);
    end
    repeat (12) @(posedge sys_clk);
    check("drained", 12'(q.size()), 12'h000);
    summarize();
  end
endmodule
